// ===== verilog/dmcp_host.v
// host controller for a dual mode (i2c or spi) converter control port
// assumes an ahb-lite master with single word transfers; pins resolved by the bench
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "dmcp_regs.vh"

module dmcp_host (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // i2c pins, open drain
  output wire scl_o,
  output wire scl_oe,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  // spi pins
  output reg control_clock,
  output reg control_serial_in,
  input wire control_serial_out,
  output reg addr_lo_or_select_n,
  output reg addr_lo_or_select_oe
);

  // ----------------------------------------
  // engine states and byte steps
  // ----------------------------------------
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_START = 5'h02;
  localparam [4:0] S_XFER = 5'h04;
  localparam [4:0] S_ACK = 5'h08;
  localparam [4:0] S_STOP = 5'h10;
  localparam [2:0] ST_AW = 3'h0;
  localparam [2:0] ST_PTR = 3'h1;
  localparam [2:0] ST_WD = 3'h2;
  localparam [2:0] ST_AR = 3'h3;
  localparam [2:0] ST_RD = 3'h4;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg wr_pend;
  reg rd_pend;
  reg [7:0] dp_addr;
  reg [6:0] cfg;
  reg [7:0] register_pointer;
  reg [31:0] wdata;
  reg [31:0] rdata;
  reg done;
  reg nack;
  reg [4:0] st;
  reg [2:0] step;
  reg [1:0] phase;
  reg [2:0] bitcnt;
  reg [7:0] shreg;
  reg [1:0] left;
  reg [1:0] bidx;
  reg restart;
  reg ack_bit;
  reg ev_done;
  reg ev_nack;
  reg scl_lvl;
  reg sda_lvl;
  reg [1:0] sync1;
  reg [1:0] sync2;
  reg [4:0] next_st;
  reg [2:0] next_step;
  reg [7:0] next_load;
  reg next_restart;
  reg [7:0] wbyte;
  wire qtick;
  wire ap;
  wire go;
  wire busy;
  wire spi;
  wire reading;
  wire last;
  wire rx;
  wire [1:0] wsel;
  wire [7:0] addr_byte;

  // ----------------------------------------
  // ahb-lite slave: writes zero wait, reads one wait
  // ----------------------------------------
  assign ap = hsel & htrans[1] & hready & (hsize == 3'h2);
  assign hreadyout = ~rd_pend;
  assign hresp = 1'b0;
  assign busy = ~st[0];
  assign go = wr_pend & (dp_addr == `DMCP_OFF_CTRL) & hwdata[`DMCP_CTRL_GO] & ~busy;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      wr_pend <= ap & hwrite;
      rd_pend <= ap & ~hwrite;
      if (ap) begin
        dp_addr <= haddr[7:0];
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= `DMCP_CTRL_RESET;
      register_pointer <= `DMCP_PTR_RESET;
      wdata <= 32'h0000_0000;
      done <= 1'b0;
      nack <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      if (wr_pend & ~busy) begin
        case (dp_addr)
          `DMCP_OFF_CTRL: cfg <= hwdata[6:0];
          `DMCP_OFF_PTR: register_pointer <= hwdata[7:0] & `DMCP_PTR_MASK;
          `DMCP_OFF_WDATA: wdata <= hwdata;
          default: ;
        endcase
      end
      // event in the clearing cycle wins over the clear
      done <= ev_done | (done & ~(wr_pend & (dp_addr == `DMCP_OFF_STATUS) &
        hwdata[`DMCP_STAT_DONE]));
      nack <= ev_nack | (nack & ~(wr_pend & (dp_addr == `DMCP_OFF_STATUS) &
        hwdata[`DMCP_STAT_NACK]));
      if (rd_pend) begin
        case (dp_addr)
          `DMCP_OFF_CTRL: hrdata <= {25'h000_0000, cfg[6:1], 1'b0};
          `DMCP_OFF_PTR: hrdata <= {24'h00_0000, register_pointer};
          `DMCP_OFF_WDATA: hrdata <= wdata;
          `DMCP_OFF_RDATA: hrdata <= rdata;
          `DMCP_OFF_STATUS: hrdata <= {29'h0000_0000, nack, done, busy};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // input synchronisers and link divider
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
    end else begin
      sync1 <= {control_serial_out, sda_i};
      sync2 <= sync1;
    end
  end

  dmcp_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(busy),
    .tick(qtick)
  );

  // ----------------------------------------
  // byte sequencing
  // ----------------------------------------
  assign spi = cfg[`DMCP_CTRL_SPI];
  assign reading = (step == ST_RD);
  assign last = (left == 2'h0);
  assign rx = spi ? sync2[1] : sync2[0];
  assign wsel = (step == ST_PTR) ? 2'h0 : bidx + 2'h1;
  assign addr_byte = spi ? ((step == ST_AR) ? `DMCP_SPI_ADDR_RD : `DMCP_SPI_ADDR_WR) :
    {`DMCP_I2C_ID, cfg[`DMCP_CTRL_AHI], cfg[`DMCP_CTRL_ALO], step == ST_AR};

  always @* begin
    case (wsel)
      2'h0: wbyte = wdata[7:0];
      2'h1: wbyte = wdata[15:8];
      2'h2: wbyte = wdata[23:16];
      default: wbyte = wdata[31:24];
    endcase
  end

  // decision taken at the end of each byte
  always @* begin
    next_st = S_XFER;
    next_step = step;
    next_load = 8'h00;
    next_restart = 1'b0;
    case (step)
      ST_AW: begin
        next_step = ST_PTR;
        next_load = register_pointer;
      end
      ST_PTR: begin
        if (cfg[`DMCP_CTRL_RD]) begin
          // pointer set first so the read returns the chosen register
          next_step = ST_AR;
          next_st = spi ? S_STOP : S_START;
          next_restart = spi;
        end else begin
          next_step = ST_WD;
          next_load = wbyte;
        end
      end
      ST_WD: begin
        if (last) begin
          next_st = S_STOP;
        end else begin
          next_load = wbyte; // device moves the pointer only if bit 7 is set
        end
      end
      ST_AR: begin
        next_step = ST_RD;
      end
      default: begin
        if (last) begin
          next_st = S_STOP;
        end
      end
    endcase
  end

  // ----------------------------------------
  // link engine, four quarter ticks per bit
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= S_IDLE;
      step <= ST_AW;
      phase <= 2'h0;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      left <= 2'h0;
      bidx <= 2'h0;
      restart <= 1'b0;
      ack_bit <= 1'b1;
      ev_done <= 1'b0;
      ev_nack <= 1'b0;
      rdata <= 32'h0000_0000;
      scl_lvl <= 1'b1;
      sda_lvl <= 1'b1;
      control_clock <= 1'b0;
      control_serial_in <= 1'b0;
      addr_lo_or_select_n <= 1'b1;
    end else begin
      ev_done <= 1'b0;
      ev_nack <= 1'b0;
      if (go) begin
        st <= S_START;
        step <= ST_AW;
        phase <= 2'h0;
        bidx <= 2'h0;
        restart <= 1'b0;
        left <= hwdata[`DMCP_CTRL_CNT_HI:`DMCP_CTRL_CNT_LO];
      end else if (qtick) begin
        phase <= phase + 2'h1;
        case (st)
          S_START: begin
            case (phase)
              2'h0: begin
                sda_lvl <= 1'b1;
                scl_lvl <= spi;
                control_clock <= 1'b0;
                // select falls only in spi mode, which moves the device over
                addr_lo_or_select_n <= ~spi;
              end
              2'h1: scl_lvl <= 1'b1;
              2'h2: sda_lvl <= spi;
              default: begin
                scl_lvl <= spi;
                shreg <= addr_byte;
                bitcnt <= 3'h0;
                st <= S_XFER;
              end
            endcase
          end
          S_XFER: begin
            case (phase)
              2'h0: begin
                if (spi) begin
                  control_clock <= 1'b0;
                  control_serial_in <= shreg[7]; // msb first
                end else begin
                  scl_lvl <= 1'b0;
                  sda_lvl <= reading | shreg[7];
                end
              end
              2'h1: begin
                // rising link clock, device samples here
                if (spi) begin
                  control_clock <= 1'b1;
                end else begin
                  scl_lvl <= 1'b1;
                end
              end
              2'h2: shreg <= {shreg[6:0], rx};
              default: begin
                bitcnt <= bitcnt + 3'h1;
                if (spi) begin
                  control_clock <= 1'b0;
                end else begin
                  scl_lvl <= 1'b0;
                end
                if (bitcnt == 3'h7) begin
                  if (!spi) begin
                    st <= S_ACK;
                  end else begin
                    if (reading) begin
                      case (bidx)
                        2'h0: rdata[7:0] <= shreg;
                        2'h1: rdata[15:8] <= shreg;
                        2'h2: rdata[23:16] <= shreg;
                        default: rdata[31:24] <= shreg;
                      endcase
                    end
                    if (reading | (step == ST_WD)) begin
                      left <= left - 2'h1;
                      bidx <= bidx + 2'h1;
                    end
                    st <= next_st;
                    step <= next_step;
                    shreg <= next_load;
                    restart <= next_restart;
                  end
                end
              end
            endcase
          end
          S_ACK: begin
            case (phase)
              2'h0: sda_lvl <= reading ? last : 1'b1;
              2'h1: scl_lvl <= 1'b1;
              2'h2: ack_bit <= rx;
              default: begin
                scl_lvl <= 1'b0;
                bitcnt <= 3'h0;
                if (!reading && ack_bit) begin
                  // no acknowledge: address unmatched or byte refused
                  ev_nack <= 1'b1;
                  st <= S_STOP;
                end else begin
                  if (reading) begin
                    case (bidx)
                      2'h0: rdata[7:0] <= shreg;
                      2'h1: rdata[15:8] <= shreg;
                      2'h2: rdata[23:16] <= shreg;
                      default: rdata[31:24] <= shreg;
                    endcase
                  end
                  if (reading | (step == ST_WD)) begin
                    left <= left - 2'h1;
                    bidx <= bidx + 2'h1;
                  end
                  st <= next_st;
                  step <= next_step;
                  shreg <= next_load;
                end
              end
            endcase
          end
          S_STOP: begin
            case (phase)
              2'h0: begin
                scl_lvl <= spi;
                sda_lvl <= spi;
                control_clock <= 1'b0;
              end
              2'h1: scl_lvl <= 1'b1;
              2'h2: begin
                sda_lvl <= 1'b1;
                addr_lo_or_select_n <= 1'b1; // only on whole bytes
              end
              default: begin
                control_serial_in <= 1'b0;
                if (restart) begin
                  restart <= 1'b0;
                  st <= S_START;
                end else begin
                  // pins rest at fixed levels until the next start
                  ev_done <= 1'b1;
                  st <= S_IDLE;
                end
              end
            endcase
          end
          default: phase <= 2'h0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_lo_or_select_oe <= 1'b0;
    end else begin
      addr_lo_or_select_oe <= spi;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = ~scl_lvl;
  assign sda_oe = ~sda_lvl;

endmodule // dmcp_host

// ===== verilog/dmcp_regs.vh
// register map, field positions and timing of the dual mode control port host
// assumes an 8 ns hclk and byte offsets compared against haddr[7:0]
`ifndef DMCP_REGS_VH
`define DMCP_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DMCP_OFF_CTRL 8'h00
`define DMCP_OFF_PTR 8'h04
`define DMCP_OFF_WDATA 8'h08
`define DMCP_OFF_RDATA 8'h0C
`define DMCP_OFF_STATUS 8'h10

// ----------------------------------------
// control fields
// ----------------------------------------
`define DMCP_CTRL_GO 0
`define DMCP_CTRL_RD 1
`define DMCP_CTRL_SPI 2
`define DMCP_CTRL_ALO 3
`define DMCP_CTRL_AHI 4
`define DMCP_CTRL_CNT_LO 5
`define DMCP_CTRL_CNT_HI 6
`define DMCP_CTRL_RESET 7'h00

// ----------------------------------------
// status fields
// ----------------------------------------
`define DMCP_STAT_BUSY 0
`define DMCP_STAT_DONE 1
`define DMCP_STAT_NACK 2

// ----------------------------------------
// pointer byte and address bytes
// ----------------------------------------
`define DMCP_PTR_AUTO_INCREMENT_ENABLE 7
`define DMCP_PTR_MASK 8'h8F
`define DMCP_PTR_RESET 8'h00
`define DMCP_I2C_ID 5'h12
`define DMCP_SPI_ADDR_WR 8'h9E
`define DMCP_SPI_ADDR_RD 8'h9F

// ----------------------------------------
// timing
// ----------------------------------------
`define DMCP_HCLK_NS 8
`define DMCP_QUARTER_NS 1250
`define DMCP_QUARTER_CYC ((`DMCP_QUARTER_NS + `DMCP_HCLK_NS - 1) / `DMCP_HCLK_NS)

`endif

// ===== verilog/dmcp_tick.v
// quarter bit period tick generator for the link clock divider
// assumes run is a level on hclk; counter restarts whenever run is low
`timescale 1ns/1ps
`include "dmcp_regs.vh"

module dmcp_tick #(
  parameter [11:0] CYC = `DMCP_QUARTER_CYC
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire run,
  output reg tick
);

  reg [11:0] cnt;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 12'h000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt <= 12'h000;
      tick <= 1'b0;
    end else if (cnt == CYC - 12'h001) begin
      cnt <= 12'h000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 12'h001;
      tick <= 1'b0;
    end
  end

endmodule // dmcp_tick

// ===== test/dmcp_host_sva.sv
// concurrent checks on the bus and link pins of the control port host
// assumes binding onto dmcp_host; hclk rising, hresetn active low
`timescale 1ns/1ps
module dmcp_host_sva (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // link
  input wire scl_oe,
  input wire sda_oe,
  input wire control_clock,
  input wire control_serial_in,
  input wire addr_lo_or_select_n,
  input wire addr_lo_or_select_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // bus transfers
  // ----------------------------------------
  sequence s_taken;
    hsel && htrans[1] && hready && hsize == 3'b010;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_one_wait: assert property (s_taken ##0 !hwrite |=> s_one_wait)
    else $error("read data phase not one wait state");
  chk_write_no_wait: assert property (s_taken ##0 hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  chk_rdata_hold: assert property ($past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed outside a read");
  // ----------------------------------------
  // link pins
  // ----------------------------------------
  chk_select_fall_driven: assert property (
    $fell(addr_lo_or_select_n) |-> addr_lo_or_select_oe)
    else $error("select fell while not driven");
  chk_clock_in_frame: assert property (
    $rose(control_clock) |-> !addr_lo_or_select_n && addr_lo_or_select_oe)
    else $error("spi clock rose outside a frame");
  chk_din_setup: assert property (
    $rose(control_clock) |-> $stable(control_serial_in))
    else $error("spi data moved at clock rise");
  chk_i2c_quiet_spi: assert property (
    addr_lo_or_select_oe |-> !scl_oe && !sda_oe)
    else $error("i2c lines pulled in spi mode");
endmodule // dmcp_host_sva

bind dmcp_host dmcp_host_sva chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .scl_oe(scl_oe), .sda_oe(sda_oe), .control_clock(control_clock),
  .control_serial_in(control_serial_in), .addr_lo_or_select_n(addr_lo_or_select_n),
  .addr_lo_or_select_oe(addr_lo_or_select_oe)
);

// ===== test/dmcp_dev_model.sv
// behavioural converter control port: register file, pointer, i2c and spi slave
// assumes pulled-up scl and sda resolved by the bench; no reset pin modelled
`timescale 1ns/1ps
module dmcp_dev_model (
  // i2c side
  input wire scl,
  input wire sda,
  output reg sda_pull,
  input wire addr_select_hi,
  // spi side, select shared with addr_select_lo
  input wire addr_lo_or_select_n,
  input wire control_clock,
  input wire control_serial_in,
  output reg control_serial_out
);
  reg [7:0] mem [0:15];
  reg [7:0] ptr;
  reg [7:0] sh;
  reg [7:0] tx;
  reg [3:0] bc;
  reg [2:0] ph;
  reg rd;
  reg act;
  reg spi;
  integer i;
  initial begin
    for (i = 0; i < 16; i = i + 1) mem[i] = 8'ha0 + i;
    ptr = 8'h00;
    {sh, tx, bc, ph, rd, act, spi, sda_pull, control_serial_out} = 0;
  end
  task bump;
    if (ptr[7]) ptr[3:0] = ptr[3:0] + 4'h1;
  endtask
  task store;
    begin
      if (ptr[3:0] != 4'h1) mem[ptr[3:0]] = sh;
      bump;
    end
  endtask
  // ----------------------------------------
  // i2c slave, link clock only
  // ----------------------------------------
  always @(negedge sda) if (scl === 1'b1 && !spi) begin
    act = 1'b1;
    bc = 4'h0;
    ph = 3'h0;
    rd = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) act = 1'b0;
  always @(posedge scl) if (act) begin
    if (bc < 4'h8) sh = {sh[6:0], sda};
    else if (rd && sda) act = 1'b0;
    bc = bc + 4'h1;
  end
  always @(negedge scl) if (act) begin
    if (bc == 4'h8 && rd) begin
      sda_pull = 1'b0;
      bump;
    end else if (bc == 4'h8) begin
      sda_pull = 1'b1;
      case (ph)
        3'h0: if (sh[7:1] == {5'h12, addr_select_hi, addr_lo_or_select_n}) begin
          rd = sh[0];
          ph = sh[0] ? 3'h2 : 3'h1;
        end else begin
          sda_pull = 1'b0;
          act = 1'b0;
        end
        3'h1: begin
          ptr = sh & 8'h8f;
          ph = 3'h2;
        end
        default: store;
      endcase
    end else if (bc == 4'h9) begin
      bc = 4'h0;
      sda_pull = 1'b0;
      if (rd) tx = mem[ptr[3:0]];
      if (rd) sda_pull = ~tx[7];
    end else if (rd) sda_pull = ~tx[7 - bc];
  end
  // ----------------------------------------
  // spi slave
  // ----------------------------------------
  always @(negedge addr_lo_or_select_n) if ($time > 0) begin
    spi = 1'b1;
    bc = 4'h0;
    ph = 3'h0;
  end
  always @(posedge addr_lo_or_select_n) if (spi) control_serial_out = ~control_serial_out;
  always @(posedge control_clock) if (spi && !addr_lo_or_select_n) begin
    sh = {sh[6:0], control_serial_in};
    bc = bc + 4'h1;
    if (bc == 4'h8) begin
      bc = 4'h0;
      case (ph)
        3'h0: ph = (sh == 8'h9e) ? 3'h1 : (sh == 8'h9f) ? 3'h3 : 3'h4;
        3'h1: begin
          ptr = sh & 8'h8f;
          ph = 3'h2;
        end
        3'h2: store;
        3'h3: bump;
        default: ;
      endcase
      tx = mem[ptr[3:0]];
    end
  end
  always @(negedge control_clock) if (spi && ph == 3'h3) control_serial_out = tx[7 - bc];
endmodule // dmcp_dev_model

// ===== test/tb_dual_mode_control_port.sv
// self-checking bench: ahb-lite master, device model, table of transfers
// assumes dmcp_host, dmcp_dev_model and the bound checker are compiled with it
`timescale 1ns/1ps
`include "dmcp_regs.vh"
module tb_dual_mode_control_port;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] ptr;
    logic [31:0] wdata;
    logic nack;
    logic [15:0] rdata;
    logic [3:0] ia;
    logic [7:0] va;
    logic [3:0] ib;
    logic [7:0] vb;
  } dmcp_row_t;
  reg hclk, hresetn, hsel, hwrite;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [31:0] haddr, hwdata, d;
  wire hreadyout, hresp, scl_o, scl_oe, sda_o, sda_oe, dev_pull, dev_out;
  wire control_clock, control_serial_in, addr_lo_or_select_n, addr_lo_or_select_oe;
  wire [31:0] hrdata;
  wire scl_w = scl_oe ? scl_o : 1'b1;
  wire sda_w = !((sda_oe && !sda_o) || dev_pull);
  wire sel_w = addr_lo_or_select_oe ? addr_lo_or_select_n : 1'b0;
  integer failures = 0;
  integer tests_run = 0;
  integer k;
  // bus answer as it stands just before the next rising edge
  reg hr_q;
  reg [31:0] hd_q;
  dmcp_row_t rows [0:4];
  dmcp_row_t r;
  dmcp_host uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .control_clock(control_clock),
    .control_serial_in(control_serial_in), .control_serial_out(dev_out),
    .addr_lo_or_select_n(addr_lo_or_select_n), .addr_lo_or_select_oe(addr_lo_or_select_oe));
  dmcp_dev_model dev (.scl(scl_w), .sda(sda_w), .sda_pull(dev_pull), .addr_select_hi(1'b1),
    .addr_lo_or_select_n(sel_w), .control_clock(control_clock),
    .control_serial_in(control_serial_in), .control_serial_out(dev_out));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(negedge hclk) begin
    hr_q = hreadyout;
    hd_q = hrdata;
  end
  // ----------------------------------------
  // bus master, compare and closing
  // ----------------------------------------
  task ahb(input [7:0] a, input w, input [31:0] wd, output [31:0] rd);
    begin
      hsel <= 1'b1;
      haddr <= {24'h0000_00, a};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hr_q !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hr_q !== 1'b1) @(posedge hclk);
      rd = hd_q;
    end
  endtask
  task chk(input [8*8-1:0] what, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #1_500_000;
    failures = failures + 1;
    $display("ERROR watchdog expected finish seen hang");
    test_done;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 0;
    hsize = 3'b010;
    rows[0] = '{8'h31, 8'hf2, 32'h0000_5533, 1'b0, 16'h0000, 4'h2, 8'h33, 4'h3, 8'h55};
    rows[1] = '{8'h33, 8'h82, 32'h0000_0000, 1'b0, 16'h5533, 4'h2, 8'h33, 4'h4, 8'ha4};
    rows[2] = '{8'h19, 8'h04, 32'h0000_00ee, 1'b1, 16'h5533, 4'h4, 8'ha4, 4'h2, 8'h33};
    rows[3] = '{8'h25, 8'h05, 32'h0000_7766, 1'b0, 16'h5533, 4'h5, 8'h77, 4'h6, 8'ha6};
    rows[4] = '{8'h07, 8'h05, 32'h0000_0000, 1'b0, 16'h5577, 4'h5, 8'h77, 4'h6, 8'ha6};
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (k = 0; k < 5; k = k + 1) begin
      r = rows[k];
      ahb(`DMCP_OFF_PTR, 1'b1, {24'h0000_00, r.ptr}, d);
      ahb(`DMCP_OFF_WDATA, 1'b1, r.wdata, d);
      ahb(`DMCP_OFF_CTRL, 1'b1, {24'h0000_00, r.ctrl}, d);
      ahb(`DMCP_OFF_PTR, 1'b1, 32'h0000_000f, d);
      ahb(`DMCP_OFF_PTR, 1'b0, 32'h0000_0000, d);
      chk("pointer", {24'h0000_00, r.ptr & 8'h8f}, d);
      d = 32'h0000_0000;
      while (d[`DMCP_STAT_DONE] !== 1'b1) ahb(`DMCP_OFF_STATUS, 1'b0, 32'h0000_0000, d);
      chk("nack", {31'h0000_0000, r.nack}, {31'h0000_0000, d[`DMCP_STAT_NACK]});
      ahb(`DMCP_OFF_STATUS, 1'b1, 32'h0000_0006, d);
      ahb(`DMCP_OFF_STATUS, 1'b0, 32'h0000_0000, d);
      chk("status", 32'h0000_0000, d);
      ahb(`DMCP_OFF_RDATA, 1'b0, 32'h0000_0000, d);
      chk("rdata", {16'h0000, r.rdata}, {16'h0000, d[15:0]});
      chk("reg a", {24'h0000_00, r.va}, {24'h0000_00, dev.mem[r.ia]});
      chk("reg b", {24'h0000_00, r.vb}, {24'h0000_00, dev.mem[r.ib]});
      $display("row %0d finished", k);
    end
    ahb(8'h20, 1'b1, 32'h0000_1234, d);
    ahb(8'h20, 1'b0, 32'h0000_0000, d);
    chk("unmapped", 32'h0000_0000, d);
    $display("unmapped test finished");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("pins", 32'h0000_0002, {27'h0, scl_oe, sda_oe, control_clock,
      addr_lo_or_select_n, addr_lo_or_select_oe});
    ahb(`DMCP_OFF_CTRL, 1'b0, 32'h0000_0000, d);
    chk("ctrl", 32'h0000_0000, d);
    ahb(`DMCP_OFF_PTR, 1'b0, 32'h0000_0000, d);
    chk("ptr rst", 32'h0000_0000, d);
    $display("reset test finished");
    test_done;
  end
endmodule // tb_dual_mode_control_port
